/* ppm_pkg.sv */
// Purpose: Shared constants, register map and types of the port pin mux.
// Assumes: Word-aligned Avalon-MM byte addresses, register index times four.
// Notes: Only bits 3..0 of port D registers are implemented.
package ppm_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int IDX_W = 6;

  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_PULLUP = 6'h00;
  localparam logic [IDX_W-1:0] IDX_DATA = 6'h01;
  localparam logic [IDX_W-1:0] IDX_DIR = 6'h02;
  localparam logic [IDX_W-1:0] IDX_PERIPH_EN = 6'h03;
  localparam logic [IDX_W-1:0] IDX_IRQ_ASSERT = 6'h04;
  localparam logic [IDX_W-1:0] IDX_IRQ_EN = 6'h05;
  localparam logic [IDX_W-1:0] IDX_IRQ_POL = 6'h06;
  localparam logic [IDX_W-1:0] IDX_IRQ_PEND = 6'h07;
  localparam logic [IDX_W-1:0] IDX_EDGE_SEEN = 6'h08;
  localparam logic [IDX_W-1:0] IDX_PUSH_PULL = 6'h09;
  localparam logic [IDX_W-1:0] IDX_RAW_LEVEL = 6'h0a;
  localparam logic [IDX_W-1:0] IDX_DRIVE = 6'h0b;
  localparam logic [IDX_W-1:0] IDX_PB_GPIO = 6'h0c;
  localparam logic [IDX_W-1:0] IDX_PSEL = 6'h0d;
  localparam logic [IDX_W-1:0] IDX_PLL_CTRL = 6'h0e;
  localparam logic [IDX_W-1:0] IDX_PC_ANALOG = 6'h0f;
  localparam logic [IDX_W-1:0] IDX_INT_STAT = 6'h10;
  localparam logic [IDX_W-1:0] IDX_INT_CLR = 6'h11;
  localparam logic [IDX_W-1:0] IDX_INT_EN = 6'h12;

  // Reset values
  localparam logic [3:0] RST_PULLUP = 4'hf;
  localparam logic [3:0] RST_PERIPH_EN = 4'hf;
  localparam logic [3:0] RST_PUSH_PULL = 4'hf;
  localparam logic [3:0] RST_ZERO4 = 4'h0;
  localparam logic [7:0] RST_PB_GPIO = 8'h00;
  localparam logic [7:0] RST_PSEL = 8'h00;
  localparam logic [7:0] RST_PC_ANALOG = 8'hff;

  // Field positions
  localparam int PB_DIR_LSB = 4;
  localparam int PSEL_ALT_LSB = 4;
  localparam int PLL_EXTCLK_BIT = 0;
  localparam int STAT_W = 2;
  localparam int STAT_TAP_RESET = 0;
  localparam int STAT_PD_EDGE = 1;
  localparam int PD_TCK_BIT = 2;
  localparam int PD_TMS_BIT = 3;
  localparam int PD_TDO_BIT = 1;
  localparam int PD_TDI_BIT = 0;

  // Consecutive TMS-high TCK edges that force the TAP reset state
  localparam logic [2:0] TMS_RESET_EDGES = 3'h5;

  typedef enum logic [3:0] {
    TAP_RESET = 4'h0, TAP_IDLE = 4'h1, TAP_SEL_DR = 4'h2, TAP_CAP_DR = 4'h3,
    TAP_SH_DR = 4'h4, TAP_EX1_DR = 4'h5, TAP_PA_DR = 4'h6, TAP_EX2_DR = 4'h7,
    TAP_UP_DR = 4'h8, TAP_SEL_IR = 4'h9, TAP_CAP_IR = 4'ha, TAP_SH_IR = 4'hb,
    TAP_EX1_IR = 4'hc, TAP_PA_IR = 4'hd, TAP_EX2_IR = 4'he, TAP_UP_IR = 4'hf
  } ppm_tap_state_e;

  // Drive requests from on-chip peripherals toward port B pins 4..7
  typedef struct packed {
    logic t0_out;
    logic t0_oe;
    logic clock_output;
    logic t1_out;
    logic t1_oe;
    logic txd;
    logic sda_pull_low;
    logic scl_pull_low;
  } ppm_pb_drive_s;

  // Pin levels delivered back to on-chip peripherals
  typedef struct packed {
    logic t0_in;
    logic t1_in;
    logic pwm_fault_input_3;
    logic rxd;
    logic sda_in;
    logic scl_in;
    logic ext_clk;
  } ppm_pb_sense_s;

endpackage : ppm_pkg

/* ppm_tap_ctrl.sv */
// Purpose: Boundary-scan TAP state machine stepped by sampled TCK edges.
// Assumes: tck_rise is a one-cycle pulse; tms and tdi are already synchronised.
// Notes: Only the bypass path is scanned; no test-reset input exists.
`timescale 1ns/100ps
module ppm_tap_ctrl (
  input wire logic clk,
  input wire logic rst,
  input wire logic tck_rise,
  input wire logic tms,
  input wire logic tdi,
  output ppm_pkg::ppm_tap_state_e state,
  output logic tdo,
  output logic tdo_en,
  output logic tms_reset
);
  ppm_pkg::ppm_tap_state_e state_r, state_nxt;
  logic bypass_r;
  logic tdo_r;
  logic tdo_en_r;
  logic tms_reset_r;
  logic [2:0] tms_cnt_r;

  // Standard sixteen-state walk, advanced only on a TCK rise
  always_comb begin
    state_nxt = state_r;
    if (tck_rise) begin
      case (state_r)
        ppm_pkg::TAP_RESET: state_nxt = tms ? ppm_pkg::TAP_RESET : ppm_pkg::TAP_IDLE;
        ppm_pkg::TAP_IDLE: state_nxt = tms ? ppm_pkg::TAP_SEL_DR : ppm_pkg::TAP_IDLE;
        ppm_pkg::TAP_SEL_DR: state_nxt = tms ? ppm_pkg::TAP_SEL_IR : ppm_pkg::TAP_CAP_DR;
        ppm_pkg::TAP_CAP_DR: state_nxt = tms ? ppm_pkg::TAP_EX1_DR : ppm_pkg::TAP_SH_DR;
        ppm_pkg::TAP_SH_DR: state_nxt = tms ? ppm_pkg::TAP_EX1_DR : ppm_pkg::TAP_SH_DR;
        ppm_pkg::TAP_EX1_DR: state_nxt = tms ? ppm_pkg::TAP_UP_DR : ppm_pkg::TAP_PA_DR;
        ppm_pkg::TAP_PA_DR: state_nxt = tms ? ppm_pkg::TAP_EX2_DR : ppm_pkg::TAP_PA_DR;
        ppm_pkg::TAP_EX2_DR: state_nxt = tms ? ppm_pkg::TAP_UP_DR : ppm_pkg::TAP_SH_DR;
        ppm_pkg::TAP_UP_DR: state_nxt = tms ? ppm_pkg::TAP_SEL_DR : ppm_pkg::TAP_IDLE;
        ppm_pkg::TAP_SEL_IR: state_nxt = tms ? ppm_pkg::TAP_RESET : ppm_pkg::TAP_CAP_IR;
        ppm_pkg::TAP_CAP_IR: state_nxt = tms ? ppm_pkg::TAP_EX1_IR : ppm_pkg::TAP_SH_IR;
        ppm_pkg::TAP_SH_IR: state_nxt = tms ? ppm_pkg::TAP_EX1_IR : ppm_pkg::TAP_SH_IR;
        ppm_pkg::TAP_EX1_IR: state_nxt = tms ? ppm_pkg::TAP_UP_IR : ppm_pkg::TAP_PA_IR;
        ppm_pkg::TAP_PA_IR: state_nxt = tms ? ppm_pkg::TAP_EX2_IR : ppm_pkg::TAP_PA_IR;
        ppm_pkg::TAP_EX2_IR: state_nxt = tms ? ppm_pkg::TAP_UP_IR : ppm_pkg::TAP_SH_IR;
        ppm_pkg::TAP_UP_IR: state_nxt = tms ? ppm_pkg::TAP_SEL_DR : ppm_pkg::TAP_IDLE;
        default: state_nxt = ppm_pkg::TAP_RESET;
      endcase
    end
  end

  // Power-on reset is the only asynchronous-free way in besides TMS
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= ppm_pkg::TAP_RESET;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Count consecutive TMS-high edges, saturating at the reset figure
  always_ff @(posedge clk) begin
    if (rst) begin
      tms_cnt_r <= 3'h0;
    end else if (tck_rise) begin
      if (!tms) begin
        tms_cnt_r <= 3'h0;
      end else if (tms_cnt_r != ppm_pkg::TMS_RESET_EDGES) begin
        tms_cnt_r <= tms_cnt_r + 3'h1;
      end
    end
  end

  // Pulse when the TMS walk lands in reset from elsewhere
  always_ff @(posedge clk) begin
    if (rst) begin
      tms_reset_r <= 1'b0;
    end else begin
      tms_reset_r <= (state_nxt == ppm_pkg::TAP_RESET) && (state_r != ppm_pkg::TAP_RESET);
    end
  end

  // Bypass cell; capture clears it so a fresh scan starts at zero
  always_ff @(posedge clk) begin
    if (rst) begin
      bypass_r <= 1'b0;
      tdo_r <= 1'b0;
      tdo_en_r <= 1'b0;
    end else begin
      if (tck_rise && (state_r == ppm_pkg::TAP_CAP_DR || state_r == ppm_pkg::TAP_CAP_IR)) begin
        bypass_r <= 1'b0;
      end else if (tck_rise && (state_r == ppm_pkg::TAP_SH_DR || state_r == ppm_pkg::TAP_SH_IR)) begin
        bypass_r <= tdi;
      end
      tdo_r <= bypass_r;
      tdo_en_r <= (state_r == ppm_pkg::TAP_SH_DR) || (state_r == ppm_pkg::TAP_SH_IR);
    end
  end

  assign state = state_r;
  assign tdo = tdo_r;
  assign tdo_en = tdo_en_r;
  assign tms_reset = tms_reset_r;

  property p_tap_por;
    @(posedge clk) rst |=> state_r == ppm_pkg::TAP_RESET;
  endproperty
  a_tap_por: assert property (p_tap_por) else $error("TAP not in reset after power-on");

  property p_tap_five;
    @(posedge clk) disable iff (rst) tms_cnt_r == ppm_pkg::TMS_RESET_EDGES |-> state_r == ppm_pkg::TAP_RESET;
  endproperty
  a_tap_five: assert property (p_tap_five) else $error("Five TMS edges did not reset TAP");

  property p_tap_hold;
    @(posedge clk) disable iff (rst)
      (state_r == ppm_pkg::TAP_RESET && !(tck_rise && !tms)) |=> state_r == ppm_pkg::TAP_RESET;
  endproperty
  a_tap_hold: assert property (p_tap_hold) else $error("TAP left reset without TMS low edge");

endmodule : ppm_tap_ctrl

/* ppm_port_mux.sv */
// Purpose: Pin-function mux for port B 4..7, port C analog and port D TAP pins.
// Assumes: Avalon-MM master holds a request until waitrequest is seen low.
// Notes: Pin levels pass a two-flop synchroniser before any logic.
`timescale 1ns/100ps
module ppm_port_mux (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic [7:0] ADDRESS,
  input wire logic READ,
  input wire logic WRITE,
  input wire logic [3:0] BYTEENABLE,
  input wire logic [31:0] WRITEDATA,
  output logic [31:0] READDATA,
  output logic WAITREQUEST,
  output logic IRQ,
  input wire logic [3:0] PB_IN,
  output logic [3:0] PB_OUT,
  output logic [3:0] PB_OE_N,
  input wire ppm_pkg::ppm_pb_drive_s PERIPH_DRIVE,
  output ppm_pkg::ppm_pb_sense_s PERIPH_SENSE,
  output logic [7:0] PC_ANALOG_EN,
  input wire logic [3:0] PD_IN,
  output logic [3:0] PD_OUT,
  output logic [3:0] PD_OE_N,
  output logic [3:0] PD_PULLUP_EN,
  output logic [3:0] PD_DRIVE_HI,
  output logic [3:0] PD_PUSH_PULL
);
  logic [ppm_pkg::IDX_W-1:0] idx;
  logic wait_r, take, wr_go;
  logic [31:0] rdata_r;
  logic [15:0] rd_mux;
  logic [3:0] wd4;
  logic [7:0] wd8;
  logic [3:0] pullup_r, data_r, dir_r, periph_en_r, irq_assert_r, irq_en_r;
  logic [3:0] irq_pol_r, edge_seen_r, push_pull_r, drive_r, edge_seen_nxt;
  logic [7:0] pb_gpio_r, psel_r, pc_analog_r;
  logic pll_extclk_r;
  logic [ppm_pkg::STAT_W-1:0] stat_r, stat_en_r, stat_nxt, stat_clr;
  logic irq_r;
  logic [7:0] pin_s1_r, pin_s2_r;
  logic [3:0] pd_prev_r, pd_lvl, pd_hit, pd_clr;
  logic [3:0] pb_lvl, pb_out_nxt, pb_oe_n_nxt, pb_out_r, pb_oe_n_r;
  logic [3:0] pd_out_nxt, pd_oe_n_nxt, pd_out_r, pd_oe_n_r;
  ppm_pkg::ppm_pb_sense_s sense_nxt, sense_r;
  logic tck_lvl, tck_prev_r, tck_rise, tms_lvl, tdi_lvl;
  logic tap_tdo, tap_tdo_en, tap_rst_pulse;

  assign idx = ADDRESS[7:2];
  assign take = (READ || WRITE) && wait_r;
  assign wr_go = WRITE && !wait_r && BYTEENABLE[0];
  assign wd4 = WRITEDATA[3:0];
  assign wd8 = WRITEDATA[7:0];

  // One wait cycle per access: waitrequest drops for exactly one cycle
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      wait_r <= 1'b1;
    end else begin
      wait_r <= !take;
    end
  end

  // Read mux; port D fields sit in the low nibble, upper bits read zero
  always_comb begin
    rd_mux = 16'h0000;
    case (idx)
      ppm_pkg::IDX_PULLUP: rd_mux = {12'h000, pullup_r};
      ppm_pkg::IDX_DATA: rd_mux = {12'h000, data_r};
      ppm_pkg::IDX_DIR: rd_mux = {12'h000, dir_r};
      ppm_pkg::IDX_PERIPH_EN: rd_mux = {12'h000, periph_en_r};
      ppm_pkg::IDX_IRQ_ASSERT: rd_mux = {12'h000, irq_assert_r};
      ppm_pkg::IDX_IRQ_EN: rd_mux = {12'h000, irq_en_r};
      ppm_pkg::IDX_IRQ_POL: rd_mux = {12'h000, irq_pol_r};
      ppm_pkg::IDX_IRQ_PEND: rd_mux = {12'h000, (edge_seen_r | irq_assert_r) & irq_en_r};
      ppm_pkg::IDX_EDGE_SEEN: rd_mux = {12'h000, edge_seen_r};
      ppm_pkg::IDX_PUSH_PULL: rd_mux = {12'h000, push_pull_r};
      ppm_pkg::IDX_RAW_LEVEL: rd_mux = {12'h000, pd_lvl};
      ppm_pkg::IDX_DRIVE: rd_mux = {12'h000, drive_r};
      ppm_pkg::IDX_PB_GPIO: rd_mux = {8'h00, pb_gpio_r};
      ppm_pkg::IDX_PSEL: rd_mux = {8'h00, psel_r};
      ppm_pkg::IDX_PLL_CTRL: rd_mux = {15'h0000, pll_extclk_r};
      ppm_pkg::IDX_PC_ANALOG: rd_mux = {8'h00, pc_analog_r};
      ppm_pkg::IDX_INT_STAT: rd_mux = {14'h0000, stat_r};
      ppm_pkg::IDX_INT_EN: rd_mux = {14'h0000, stat_en_r};
      default: rd_mux = 16'h0000; // Unmapped and write-only read as zero
    endcase
  end

  // Read data is latched as the request is taken and stands while waitrequest is low
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      rdata_r <= 32'h00000000;
    end else if (take) begin
      rdata_r <= READ ? {16'h0000, rd_mux} : 32'h00000000;
    end
  end

  // Port D control registers
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      pullup_r <= ppm_pkg::RST_PULLUP;
      data_r <= ppm_pkg::RST_ZERO4;
      dir_r <= ppm_pkg::RST_ZERO4;
      periph_en_r <= ppm_pkg::RST_PERIPH_EN;
      irq_assert_r <= ppm_pkg::RST_ZERO4;
      irq_en_r <= ppm_pkg::RST_ZERO4;
      irq_pol_r <= ppm_pkg::RST_ZERO4;
      push_pull_r <= ppm_pkg::RST_PUSH_PULL;
      drive_r <= ppm_pkg::RST_ZERO4;
    end else if (wr_go) begin
      if (idx == ppm_pkg::IDX_PULLUP) pullup_r <= wd4;
      if (idx == ppm_pkg::IDX_DATA) data_r <= wd4;
      if (idx == ppm_pkg::IDX_DIR) dir_r <= wd4;
      if (idx == ppm_pkg::IDX_PERIPH_EN) periph_en_r <= wd4;
      if (idx == ppm_pkg::IDX_IRQ_ASSERT) irq_assert_r <= wd4;
      if (idx == ppm_pkg::IDX_IRQ_EN) irq_en_r <= wd4;
      if (idx == ppm_pkg::IDX_IRQ_POL) irq_pol_r <= wd4;
      if (idx == ppm_pkg::IDX_PUSH_PULL) push_pull_r <= wd4;
      if (idx == ppm_pkg::IDX_DRIVE) drive_r <= wd4;
    end
  end

  // Port B, port C, clock-generation and interrupt-enable control registers
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      pb_gpio_r <= ppm_pkg::RST_PB_GPIO;
      psel_r <= ppm_pkg::RST_PSEL;
      pll_extclk_r <= 1'b0;
      pc_analog_r <= ppm_pkg::RST_PC_ANALOG;
      stat_en_r <= '0;
    end else if (wr_go) begin
      if (idx == ppm_pkg::IDX_PB_GPIO) pb_gpio_r <= wd8;
      if (idx == ppm_pkg::IDX_PSEL) psel_r <= wd8;
      if (idx == ppm_pkg::IDX_PLL_CTRL) pll_extclk_r <= WRITEDATA[ppm_pkg::PLL_EXTCLK_BIT];
      if (idx == ppm_pkg::IDX_PC_ANALOG) pc_analog_r <= wd8;
      if (idx == ppm_pkg::IDX_INT_EN) stat_en_r <= WRITEDATA[ppm_pkg::STAT_W-1:0];
    end
  end

  // Two-flop synchroniser for all pin inputs; stage one feeds only stage two
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      pin_s1_r <= 8'h00;
      pin_s2_r <= 8'h00;
      pd_prev_r <= 4'h0;
      tck_prev_r <= 1'b0;
    end else begin
      pin_s1_r <= {PD_IN, PB_IN};
      pin_s2_r <= pin_s1_r;
      pd_prev_r <= pd_lvl;
      tck_prev_r <= tck_lvl;
    end
  end

  assign pb_lvl = pin_s2_r[3:0];
  assign pd_lvl = pin_s2_r[7:4];
  // TAP inputs are tied to idle levels in logic when the pin is GPIO: TCK low, TMS and TDI high
  assign tck_lvl = periph_en_r[ppm_pkg::PD_TCK_BIT] && pd_lvl[ppm_pkg::PD_TCK_BIT];
  assign tms_lvl = !periph_en_r[ppm_pkg::PD_TMS_BIT] || pd_lvl[ppm_pkg::PD_TMS_BIT];
  assign tdi_lvl = !periph_en_r[ppm_pkg::PD_TDI_BIT] || pd_lvl[ppm_pkg::PD_TDI_BIT];
  assign tck_rise = tck_lvl && !tck_prev_r;

  // TAP state machine; only power-on reset and TMS reach its reset state
  ppm_tap_ctrl u_tap (
    .clk(CLK_SYS),
    .rst(RST),
    .tck_rise(tck_rise),
    .tms(tms_lvl),
    .tdi(tdi_lvl),
    .state(),
    .tdo(tap_tdo),
    .tdo_en(tap_tdo_en),
    .tms_reset(tap_rst_pulse)
  );

  // Port D edge capture: polarity 0 rising, 1 falling; set beats a write-one clear
  assign pd_hit = irq_en_r & ((~irq_pol_r & pd_lvl & ~pd_prev_r) | (irq_pol_r & ~pd_lvl & pd_prev_r));
  assign pd_clr = (wr_go && idx == ppm_pkg::IDX_EDGE_SEEN) ? wd4 : 4'h0;
  assign edge_seen_nxt = (edge_seen_r & ~pd_clr) | pd_hit;
  assign stat_clr = (wr_go && idx == ppm_pkg::IDX_INT_CLR) ? WRITEDATA[ppm_pkg::STAT_W-1:0] : '0;

  always_comb begin
    stat_nxt = stat_r & ~stat_clr;
    stat_nxt[ppm_pkg::STAT_TAP_RESET] = stat_nxt[ppm_pkg::STAT_TAP_RESET] | tap_rst_pulse;
    stat_nxt[ppm_pkg::STAT_PD_EDGE] = stat_nxt[ppm_pkg::STAT_PD_EDGE] | (|pd_hit);
  end

  // Sticky status and level interrupt, one cycle behind the status
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      edge_seen_r <= 4'h0;
      stat_r <= '0;
      irq_r <= 1'b0;
    end else begin
      edge_seen_r <= edge_seen_nxt;
      stat_r <= stat_nxt;
      irq_r <= |(stat_r & stat_en_r);
    end
  end

  // Port B mux: low psel bits enable the peripheral, high bits pick the alternate
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pb_out_nxt[i] = pb_gpio_r[i];
      pb_oe_n_nxt[i] = !pb_gpio_r[ppm_pkg::PB_DIR_LSB + i];
    end
    sense_nxt = '0;
    if (psel_r[0]) begin
      pb_out_nxt[0] = psel_r[ppm_pkg::PSEL_ALT_LSB] ? PERIPH_DRIVE.clock_output : PERIPH_DRIVE.t0_out;
      pb_oe_n_nxt[0] = psel_r[ppm_pkg::PSEL_ALT_LSB] ? 1'b0 : !PERIPH_DRIVE.t0_oe;
      sense_nxt.t0_in = !psel_r[ppm_pkg::PSEL_ALT_LSB] && pb_lvl[0];
    end
    if (psel_r[1]) begin
      pb_out_nxt[1] = PERIPH_DRIVE.t1_out;
      pb_oe_n_nxt[1] = psel_r[ppm_pkg::PSEL_ALT_LSB + 1] || !PERIPH_DRIVE.t1_oe;
      sense_nxt.t1_in = !psel_r[ppm_pkg::PSEL_ALT_LSB + 1] && pb_lvl[1];
      sense_nxt.pwm_fault_input_3 = psel_r[ppm_pkg::PSEL_ALT_LSB + 1] && pb_lvl[1];
    end
    if (psel_r[2]) begin
      pb_out_nxt[2] = 1'b0; // SDA is open drain: only pulls low
      pb_oe_n_nxt[2] = !(psel_r[ppm_pkg::PSEL_ALT_LSB + 2] && PERIPH_DRIVE.sda_pull_low);
      sense_nxt.rxd = !psel_r[ppm_pkg::PSEL_ALT_LSB + 2] && pb_lvl[2];
      sense_nxt.sda_in = psel_r[ppm_pkg::PSEL_ALT_LSB + 2] && pb_lvl[2];
    end
    if (psel_r[3]) begin
      pb_out_nxt[3] = psel_r[ppm_pkg::PSEL_ALT_LSB + 3] ? 1'b0 : PERIPH_DRIVE.txd;
      pb_oe_n_nxt[3] = psel_r[ppm_pkg::PSEL_ALT_LSB + 3] ? !PERIPH_DRIVE.scl_pull_low : 1'b0;
      sense_nxt.scl_in = psel_r[ppm_pkg::PSEL_ALT_LSB + 3] && pb_lvl[3];
    end
    // External clock bypasses the select register entirely
    sense_nxt.ext_clk = pll_extclk_r && pb_lvl[2];
  end

  // Port D: GPIO drive honours open-drain mode; TDO pin follows the TAP shift
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pd_out_nxt[i] = data_r[i];
      pd_oe_n_nxt[i] = periph_en_r[i] || !dir_r[i] || (!push_pull_r[i] && data_r[i]);
    end
    if (periph_en_r[ppm_pkg::PD_TDO_BIT]) begin
      pd_out_nxt[ppm_pkg::PD_TDO_BIT] = tap_tdo;
      pd_oe_n_nxt[ppm_pkg::PD_TDO_BIT] = !tap_tdo_en;
    end
  end

  // Pin and peripheral outputs all leave from flops
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      pb_out_r <= 4'h0;
      pb_oe_n_r <= 4'hf;
      pd_out_r <= 4'h0;
      pd_oe_n_r <= 4'hf;
      sense_r <= '0;
    end else begin
      pb_out_r <= pb_out_nxt;
      pb_oe_n_r <= pb_oe_n_nxt;
      pd_out_r <= pd_out_nxt;
      pd_oe_n_r <= pd_oe_n_nxt;
      sense_r <= sense_nxt;
    end
  end

  assign READDATA = rdata_r;
  assign WAITREQUEST = wait_r;
  assign IRQ = irq_r;
  assign PB_OUT = pb_out_r;
  assign PB_OE_N = pb_oe_n_r;
  assign PERIPH_SENSE = sense_r;
  assign PC_ANALOG_EN = pc_analog_r;
  assign PD_OUT = pd_out_r;
  assign PD_OE_N = pd_oe_n_r;
  assign PD_PULLUP_EN = pullup_r;
  assign PD_DRIVE_HI = drive_r;
  assign PD_PUSH_PULL = push_pull_r;

  property p_pb_gpio;
    @(posedge CLK_SYS) disable iff (RST)
      (!psel_r[0] && pb_gpio_r[ppm_pkg::PB_DIR_LSB]) |=> (PB_OUT[0] == $past(pb_gpio_r[0]) && !PB_OE_N[0]);
  endproperty
  a_pb_gpio: assert property (p_pb_gpio) else $error("Port B pin 4 GPIO drive wrong");

  property p_pb_rxd;
    @(posedge CLK_SYS) disable iff (RST)
      (psel_r[2] && !psel_r[ppm_pkg::PSEL_ALT_LSB + 2]) |=> (PERIPH_SENSE.rxd == $past(pb_lvl[2]) && PB_OE_N[2]);
  endproperty
  a_pb_rxd: assert property (p_pb_rxd) else $error("Port B pin 6 receive routing wrong");

  property p_ext_clk;
    @(posedge CLK_SYS) disable iff (RST) 1'b1 |=> PERIPH_SENSE.ext_clk == $past(pll_extclk_r && pb_lvl[2]);
  endproperty
  a_ext_clk: assert property (p_ext_clk) else $error("External clock input gating wrong");

  property p_pc_reset;
    @(posedge CLK_SYS) $past(RST) |-> PC_ANALOG_EN == ppm_pkg::RST_PC_ANALOG;
  endproperty
  a_pc_reset: assert property (p_pc_reset) else $error("Port C not analog after reset");

  property p_pd_upper;
    @(posedge CLK_SYS) disable iff (RST)
      (!WAITREQUEST && READ && idx <= ppm_pkg::IDX_DRIVE) |-> READDATA[31:4] == 28'h0000000;
  endproperty
  a_pd_upper: assert property (p_pd_upper) else $error("Port D upper bits not zero");

  property p_psel_reset;
    @(posedge CLK_SYS) $past(RST) |-> (psel_r == ppm_pkg::RST_PSEL && PB_OE_N == 4'hf);
  endproperty
  a_psel_reset: assert property (p_psel_reset) else $error("Select register not at first function");

  property p_bus_answer;
    @(posedge CLK_SYS) disable iff (RST) ((READ || WRITE) && WAITREQUEST) |=> !WAITREQUEST ##1 WAITREQUEST;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("Bus answer not one cycle");

  property p_edge_wins;
    @(posedge CLK_SYS) disable iff (RST) (|pd_hit) |=> (edge_seen_r & $past(pd_hit)) == $past(pd_hit);
  endproperty
  a_edge_wins: assert property (p_edge_wins) else $error("Edge lost against clear");

endmodule : ppm_port_mux

/* ppm_board.sv */
// Purpose: Board model: a test probe on port D and drivers on port B.
// Assumes: A released TDO line floats to the pull-up level; released port B lines follow the board drivers.
// Notes: The probe is stepped by the bench through tck_step.
`timescale 1ns/100ps
module ppm_board (
  input wire logic clk,
  input wire logic [3:0] pd_out,
  input wire logic [3:0] pd_oe_n,
  output logic [3:0] pd_in,
  input wire logic [3:0] pb_out,
  input wire logic [3:0] pb_oe_n,
  output logic [3:0] pb_in
);
  logic tck_r = 1'b0;
  logic tms_r = 1'b1;
  logic tdi_r = 1'b1;
  logic [3:0] pb_ext_r = 4'h0;
  // Wire levels; a released TDO line is pulled high
  assign pd_in = {tms_r, tck_r, pd_oe_n[1] ? 1'b1 : pd_out[1], tdi_r};
  assign pb_in = (pb_oe_n & pb_ext_r) | (~pb_oe_n & pb_out);

  // One TCK period; three system cycles per phase for the edge detector
  task tck_step(input logic tms);
    tms_r <= tms;
    repeat (3) @(posedge clk);
    tck_r <= 1'b1;
    repeat (3) @(posedge clk);
    tck_r <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : tck_step
endmodule : ppm_board

/* ppm_port_mux_tb.sv */
// Purpose: Self-checking bench for the port pin mux.
// Assumes: Bus answers are awaited under a bounded loop.
// Notes: TAP state is seen through the TDO enable and the status register.
`timescale 1ns/100ps
module ppm_port_mux_tb;
  logic CLK_SYS = 0, RST = 1, READ = 0, WRITE = 0, WAITREQUEST, IRQ;
  logic [7:0] ADDRESS = 8'h00, PC_ANALOG_EN;
  logic [3:0] BYTEENABLE = 4'hf, PB_IN, PB_OUT, PB_OE_N, PD_IN, PD_OUT, PD_OE_N;
  logic [3:0] PD_PULLUP_EN, PD_DRIVE_HI, PD_PUSH_PULL;
  logic [31:0] WRITEDATA = 32'h0, READDATA, rd;
  ppm_pkg::ppm_pb_drive_s PERIPH_DRIVE = '0;
  ppm_pkg::ppm_pb_sense_s PERIPH_SENSE;
  int err_count = 0, n_tests = 0;
  logic [3:0] rst_tab [12] = '{4'hf, 0, 0, 4'hf, 0, 0, 0, 0, 0, 4'hf, 4'hb, 0};
  // 25 MHz system clock
  always #20 CLK_SYS = ~CLK_SYS;

  ppm_port_mux dut (.CLK_SYS(CLK_SYS), .RST(RST), .ADDRESS(ADDRESS), .READ(READ),
    .WRITE(WRITE), .BYTEENABLE(BYTEENABLE), .WRITEDATA(WRITEDATA), .READDATA(READDATA),
    .WAITREQUEST(WAITREQUEST), .IRQ(IRQ), .PB_IN(PB_IN), .PB_OUT(PB_OUT),
    .PB_OE_N(PB_OE_N), .PERIPH_DRIVE(PERIPH_DRIVE), .PERIPH_SENSE(PERIPH_SENSE),
    .PC_ANALOG_EN(PC_ANALOG_EN), .PD_IN(PD_IN), .PD_OUT(PD_OUT), .PD_OE_N(PD_OE_N),
    .PD_PULLUP_EN(PD_PULLUP_EN), .PD_DRIVE_HI(PD_DRIVE_HI), .PD_PUSH_PULL(PD_PUSH_PULL));
  ppm_board brd (.clk(CLK_SYS), .pd_out(PD_OUT), .pd_oe_n(PD_OE_N), .pd_in(PD_IN),
    .pb_out(PB_OUT), .pb_oe_n(PB_OE_N), .pb_in(PB_IN));

  task final_report;
    $display("Checks %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : final_report

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk

  // One access, held until waitrequest is sampled low; read data taken there
  task bus(input logic wr, input logic [5:0] idx, input logic [31:0] wd);
    int n;
    @(posedge CLK_SYS);
    ADDRESS <= {idx, 2'b00};
    WRITEDATA <= wd;
    WRITE <= wr;
    READ <= ~wr;
    for (n = 0; n < 20; n++) begin
      @(posedge CLK_SYS);
      if (WAITREQUEST === 1'b0) break;
    end
    rd = READDATA;
    READ <= 1'b0;
    WRITE <= 1'b0;
    if (n == 20) begin
      err_count++;
      final_report();
    end
  endtask : bus

  task do_reset;
    RST <= 1'b1;
    repeat (10) @(posedge CLK_SYS);
    RST <= 1'b0;
    repeat (2) @(posedge CLK_SYS);
  endtask : do_reset

  // Reset -> idle -> select -> capture -> shift data
  task go_shift;
    brd.tck_step(1'b0);
    brd.tck_step(1'b1);
    brd.tck_step(1'b0);
    brd.tck_step(1'b0);
  endtask : go_shift

  // Main sequence
  initial begin
    do_reset();
    for (int i = 0; i < 12; i++) begin
      bus(1'b0, i[5:0], 0);
      chk(rd, {28'h0, rst_tab[i]});
    end
    bus(1'b0, ppm_pkg::IDX_PSEL, 0);
    chk(rd, 0);
    chk(PB_OE_N, 4'hf);
    chk(PERIPH_SENSE, 0);
    chk(PC_ANALOG_EN, 8'hff);
    chk({PD_PULLUP_EN, PD_DRIVE_HI, PD_PUSH_PULL}, 12'hf0f);
    bus(1'b1, ppm_pkg::IDX_DRIVE, 32'hffff_ffff);
    bus(1'b0, ppm_pkg::IDX_DRIVE, 0);
    chk(rd, 32'hf);
    chk(PD_DRIVE_HI, 4'hf);
    // A write with the low byte lane off must be dropped
    BYTEENABLE <= 4'h0;
    bus(1'b1, ppm_pkg::IDX_DRIVE, 0);
    BYTEENABLE <= 4'hf;
    bus(1'b0, ppm_pkg::IDX_DRIVE, 0);
    chk(rd, 32'hf);
    bus(1'b1, ppm_pkg::IDX_RAW_LEVEL, 0);
    bus(1'b0, ppm_pkg::IDX_RAW_LEVEL, 0);
    chk(rd, 32'hb);
    bus(1'b0, 6'h13, 0);
    chk(rd, 0);
    // Pin 4: timer drive, then clock out with the timer held low
    PERIPH_DRIVE.t0_out <= 1'b1;
    PERIPH_DRIVE.t0_oe <= 1'b1;
    bus(1'b1, ppm_pkg::IDX_PSEL, 32'h01);
    repeat (2) @(posedge CLK_SYS);
    chk({PB_OE_N[0], PB_OUT[0]}, 2'b01);
    PERIPH_DRIVE.t0_out <= 1'b0;
    PERIPH_DRIVE.clock_output <= 1'b1;
    bus(1'b1, ppm_pkg::IDX_PSEL, 32'h11);
    repeat (2) @(posedge CLK_SYS);
    chk({PB_OE_N[0], PB_OUT[0]}, 2'b01);
    // Pin 6 high from the board: receive, then data line; no clock yet
    brd.pb_ext_r <= 4'h4;
    bus(1'b1, ppm_pkg::IDX_PSEL, 32'h04);
    repeat (4) @(posedge CLK_SYS);
    chk({PERIPH_SENSE.rxd, PERIPH_SENSE.sda_in}, 2'b10);
    bus(1'b1, ppm_pkg::IDX_PSEL, 32'h44);
    repeat (4) @(posedge CLK_SYS);
    chk({PERIPH_SENSE.rxd, PERIPH_SENSE.sda_in, PERIPH_SENSE.ext_clk}, 3'b010);
    bus(1'b1, ppm_pkg::IDX_PSEL, 0);
    bus(1'b1, ppm_pkg::IDX_PLL_CTRL, 32'h1);
    repeat (4) @(posedge CLK_SYS);
    chk(PERIPH_SENSE.ext_clk, 1);
    // Pins 5..7: timer and transmit, then fault input and both open-drain lines
    PERIPH_DRIVE <= '{t0_out: 1'b0, t0_oe: 1'b1, clock_output: 1'b1, t1_out: 1'b1, t1_oe: 1'b1,
      txd: 1'b1, sda_pull_low: 1'b1, scl_pull_low: 1'b1};
    brd.pb_ext_r <= 4'h6;
    bus(1'b1, ppm_pkg::IDX_PSEL, 32'h0a);
    repeat (2) @(posedge CLK_SYS);
    chk({PB_OE_N[3], PB_OUT[3], PB_OE_N[1], PB_OUT[1]}, 4'h5);
    bus(1'b1, ppm_pkg::IDX_PSEL, 32'hee);
    repeat (5) @(posedge CLK_SYS);
    chk({PB_OE_N[3:1], PB_OUT[3:1]}, 6'h09);
    chk({PERIPH_SENSE.pwm_fault_input_3, PERIPH_SENSE.sda_in, PERIPH_SENSE.t1_in}, 3'h4);
    // Pin 4 back as GPIO, driven high by software
    bus(1'b1, ppm_pkg::IDX_PB_GPIO, 32'h11);
    repeat (2) @(posedge CLK_SYS);
    chk({PB_OE_N[0], PB_OUT[0]}, 2'b01);
    // Soft reset from shift: four TMS-high steps are not enough, five are
    go_shift();
    chk(PD_OE_N[1], 0);
    repeat (4) brd.tck_step(1'b1);
    bus(1'b0, ppm_pkg::IDX_INT_STAT, 0);
    chk(rd, 0);
    brd.tck_step(1'b1);
    bus(1'b0, ppm_pkg::IDX_INT_STAT, 0);
    chk(rd, 1);
    // Interrupt raised, masked, cleared
    bus(1'b1, ppm_pkg::IDX_INT_EN, 1);
    repeat (2) @(posedge CLK_SYS);
    chk(IRQ, 1);
    bus(1'b1, ppm_pkg::IDX_INT_EN, 0);
    repeat (2) @(posedge CLK_SYS);
    chk(IRQ, 0);
    bus(1'b1, ppm_pkg::IDX_INT_EN, 1);
    bus(1'b1, ppm_pkg::IDX_INT_CLR, 1);
    repeat (2) @(posedge CLK_SYS);
    chk(IRQ, 0);
    // System reset in mid-shift must bring the TAP back to its reset state
    go_shift();
    do_reset();
    // Wait long enough for a stale shift state to reach the TDO enable
    repeat (3) @(posedge CLK_SYS);
    chk(PD_OE_N[1], 1);
    go_shift();
    chk(PD_OE_N[1], 0);
    final_report();
  end
endmodule : ppm_port_mux_tb
